/* rtl/spcd_ctrl.sv */
// Host-side controller issuing sector protection command sequences to the flash
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
`include "spcd_defines.svh"

module spcd_ctrl (
   input  wire logic                    mclk,
   input  wire logic                    nrst,
   // Software register port
   input  wire logic [7:0]              reg_addr,
   input  wire logic [31:0]             reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic      [31:0]             reg_rdata,
   // Device bus-cycle port
   output logic                         dev_req,
   output logic                         dev_we,
   output logic      [`SPCD_AW-1:0]     dev_addr,
   output logic      [`SPCD_DW-1:0]     dev_wdata,
   input  wire logic                    dev_ack,
   input  wire logic [`SPCD_DW-1:0]     dev_rdata
);

   // ************************************************************************
   // Cycle table
   // ************************************************************************

   // Packed cycle: {last, we, addr, data}
   localparam int CYC_W = 2 + `SPCD_AW + `SPCD_DW;

   // One function call gives both the issued cycle and its last flag
   function automatic logic [CYC_W-1:0] seq_cycle(
      input spcd_pkg::spcd_cmd_t cmd,
      input logic [1:0]          idx,
      input logic [`SPCD_AW-1:0] sa,
      input logic [`SPCD_DW-1:0] wd
   );
      logic [CYC_W-1:0] c;
      c = {1'b1, 1'b1, `SPCD_ANY_ADDR, `SPCD_D_RESET};
      case (cmd)
         spcd_pkg::SPCD_C_LOCK_ENTRY, spcd_pkg::SPCD_C_VOL_ENTRY: begin
            // Unlock pair then mode code; upper address bits held zero [R1] [R5] [R13]
            if (idx == 2'h0) begin
               c = {1'b0, 1'b1, `SPCD_UNLOCK1, `SPCD_D_AA};
            end else if (idx == 2'h1) begin
               c = {1'b0, 1'b1, `SPCD_UNLOCK2, `SPCD_D_55};
            end else if (cmd == spcd_pkg::SPCD_C_LOCK_ENTRY) begin
               c = {1'b1, 1'b1, `SPCD_UNLOCK1, `SPCD_D_LOCK_ENT};
            end else begin
               c = {1'b1, 1'b1, `SPCD_UNLOCK1, `SPCD_D_VOL_ENT};
            end
         end
         spcd_pkg::SPCD_C_LOCK_CLEAR: begin
            // A0 then zero clears the freeze bit [R2]
            if (idx == 2'h0) begin
               c = {1'b0, 1'b1, `SPCD_ANY_ADDR, `SPCD_D_PROG};
            end else begin
               c = {1'b1, 1'b1, `SPCD_ANY_ADDR, `SPCD_D_ZERO};
            end
         end
         spcd_pkg::SPCD_C_LOCK_READ: begin
            c = {1'b1, 1'b0, `SPCD_ANY_ADDR, `SPCD_D_ZERO}; // [R2] [R11]
         end
         spcd_pkg::SPCD_C_EXIT: begin
            // Two-write exit back to array reads [R3]
            if (idx == 2'h0) begin
               c = {1'b0, 1'b1, `SPCD_ANY_ADDR, `SPCD_D_EXIT};
            end else begin
               c = {1'b1, 1'b1, `SPCD_ANY_ADDR, `SPCD_D_ZERO};
            end
         end
         spcd_pkg::SPCD_C_VOL_WRITE: begin
            // Full sector address so parameter sectors are hit [R22]
            if (idx == 2'h0) begin
               c = {1'b0, 1'b1, `SPCD_ANY_ADDR, `SPCD_D_PROG};
            end else begin
               c = {1'b1, 1'b1, sa, {15'h0000, wd[0]}};
            end
         end
         spcd_pkg::SPCD_C_VOL_READ, spcd_pkg::SPCD_C_ARRAY_READ: begin
            c = {1'b1, 1'b0, sa, `SPCD_D_ZERO}; // [R11] [R14]
         end
         spcd_pkg::SPCD_C_PROT_STAT: begin
            // 60 write then read at the sector [R11]
            if (idx == 2'h0) begin
               c = {1'b0, 1'b1, `SPCD_ANY_ADDR, `SPCD_D_PSTAT};
            end else begin
               c = {1'b1, 1'b0, sa, `SPCD_D_ZERO};
            end
         end
         default: begin
            // No buffer program or password word is ever sent: no abort or order hazard [R18] [R19]
            c = {1'b1, 1'b1, `SPCD_ANY_ADDR, `SPCD_D_RESET}; // Single F0 [R3]
         end
      endcase
      return c;
   endfunction : seq_cycle

   // ************************************************************************
   // State
   // ************************************************************************

   spcd_pkg::spcd_state_t        state_q;
   spcd_pkg::spcd_mode_t         mode_q;
   spcd_pkg::spcd_cmd_t          cmd_q;
   logic [1:0]                   idx_q;
   logic [`SPCD_AW-1:0]          sa_q;
   logic [`SPCD_DW-1:0]          wd_q;
   logic [`SPCD_DW-1:0]          rd_q;
   logic                         err_q;
   logic                         operr_q;
   logic [CYC_W-1:0]             cyc;
   logic                         start;
   logic                         legal;
   logic                         err_set;
   logic                         err_clr;

   assign cyc     = seq_cycle(cmd_q, idx_q, sa_q, wd_q);
   assign start   = reg_wr && (reg_addr == `SPCD_OFS_CTRL);
   assign err_clr = reg_wr && (reg_addr == `SPCD_OFS_STATUS) && reg_wdata[`SPCD_ST_ERR];

   // Entries only from array mode; overlay commands only in their own mode [R4]
   always_comb begin
      legal = 1'b0;
      case (spcd_pkg::spcd_cmd_t'(reg_wdata[3:0]))
         spcd_pkg::SPCD_C_LOCK_ENTRY,
         spcd_pkg::SPCD_C_VOL_ENTRY,
         spcd_pkg::SPCD_C_ARRAY_READ: legal = (mode_q == spcd_pkg::SPCD_MODE_ARRAY);
         spcd_pkg::SPCD_C_LOCK_CLEAR,
         spcd_pkg::SPCD_C_LOCK_READ:  legal = (mode_q == spcd_pkg::SPCD_MODE_LOCK);
         spcd_pkg::SPCD_C_VOL_WRITE,
         spcd_pkg::SPCD_C_VOL_READ,
         spcd_pkg::SPCD_C_PROT_STAT:  legal = (mode_q == spcd_pkg::SPCD_MODE_VOL);
         spcd_pkg::SPCD_C_EXIT,
         spcd_pkg::SPCD_C_RESET:      legal = 1'b1;
         default:                     legal = 1'b0;
      endcase
   end

   // Order while busy or in the wrong mode is refused and flagged
   assign err_set = start && ((state_q != spcd_pkg::SPCD_IDLE) || !legal);

   // Sequencer; the request is held until the device acknowledges it
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_q <= spcd_pkg::SPCD_IDLE;
         cmd_q   <= spcd_pkg::SPCD_C_RESET;
         idx_q   <= 2'h0;
      end else begin
         case (state_q)
            spcd_pkg::SPCD_IDLE: begin
               if (start && !err_set) begin
                  cmd_q   <= spcd_pkg::spcd_cmd_t'(reg_wdata[3:0]);
                  idx_q   <= 2'h0;
                  state_q <= spcd_pkg::SPCD_ISSUE;
               end
            end
            spcd_pkg::SPCD_ISSUE: begin
               if (dev_ack) begin
                  state_q <= cyc[CYC_W-1] ? spcd_pkg::SPCD_DONE : spcd_pkg::SPCD_NEXT;
               end
            end
            spcd_pkg::SPCD_NEXT: begin
               idx_q   <= idx_q + 2'h1;
               state_q <= spcd_pkg::SPCD_ISSUE;
            end
            spcd_pkg::SPCD_DONE: begin
               state_q <= spcd_pkg::SPCD_IDLE;
            end
            default: begin
               state_q <= spcd_pkg::SPCD_IDLE;
            end
         endcase
      end
   end

   // Mode tracking on sequence completion [R3] [R4]
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         mode_q <= spcd_pkg::SPCD_MODE_ARRAY;
      end else if (state_q == spcd_pkg::SPCD_DONE) begin
         if (cmd_q == spcd_pkg::SPCD_C_LOCK_ENTRY) begin
            mode_q <= spcd_pkg::SPCD_MODE_LOCK;
         end else if (cmd_q == spcd_pkg::SPCD_C_VOL_ENTRY) begin
            mode_q <= spcd_pkg::SPCD_MODE_VOL;
         end else if (cmd_q == spcd_pkg::SPCD_C_EXIT || cmd_q == spcd_pkg::SPCD_C_RESET) begin
            mode_q <= spcd_pkg::SPCD_MODE_ARRAY;
         end
      end
   end

   // Device bus outputs from flip-flops, loaded when a cycle is presented
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         dev_req   <= 1'b0;
         dev_we    <= 1'b0;
         dev_addr  <= '0;
         dev_wdata <= '0;
      end else if (state_q == spcd_pkg::SPCD_ISSUE && !dev_req) begin
         dev_req   <= 1'b1;
         dev_we    <= cyc[CYC_W-2];
         dev_addr  <= cyc[`SPCD_AW+`SPCD_DW-1:`SPCD_DW];
         dev_wdata <= cyc[`SPCD_DW-1:0]; // Upper byte zero in command writes
      end else if (dev_ack) begin
         dev_req   <= 1'b0;
      end
   end

   // Only the first read word is kept; the error flag watch covers reset need [R9] [R15]
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rd_q    <= '0;
         operr_q <= 1'b0;
      end else if (dev_req && dev_ack && !dev_we) begin
         rd_q    <= dev_rdata;
         operr_q <= dev_rdata[`SPCD_OPERR_BIT] && (cmd_q != spcd_pkg::SPCD_C_ARRAY_READ);
      end else if (state_q == spcd_pkg::SPCD_DONE && cmd_q == spcd_pkg::SPCD_C_RESET) begin
         operr_q <= 1'b0;
      end
   end

   // ************************************************************************
   // Register port
   // ************************************************************************

   // Address and data registers, writable only while idle to keep a sequence coherent
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sa_q <= '0;
         wd_q <= '0;
      end else if (reg_wr && state_q == spcd_pkg::SPCD_IDLE) begin
         if (reg_addr == `SPCD_OFS_ADDR) begin
            sa_q <= reg_wdata[`SPCD_AW-1:0];
         end else if (reg_addr == `SPCD_OFS_WDATA) begin
            wd_q <= reg_wdata[`SPCD_DW-1:0];
         end
      end
   end

   // Sticky refusal flag; a new refusal wins over a clear in the same cycle
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         err_q <= 1'b0;
      end else if (err_set) begin
         err_q <= 1'b1;
      end else if (err_clr) begin
         err_q <= 1'b0;
      end
   end

   // Read data one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         if (reg_addr == `SPCD_OFS_ADDR) begin
            reg_rdata <= {8'h00, sa_q};
         end else if (reg_addr == `SPCD_OFS_WDATA) begin
            reg_rdata <= {16'h0000, wd_q};
         end else if (reg_addr == `SPCD_OFS_STATUS) begin
            reg_rdata <= {27'h0000000, operr_q, err_q, mode_q,
                          state_q != spcd_pkg::SPCD_IDLE};
         end else if (reg_addr == `SPCD_OFS_RDATA) begin
            reg_rdata <= {16'h0000, rd_q};
         end else begin
            reg_rdata <= '0;
         end
      end else begin
         reg_rdata <= '0;
      end
   end

   // ************************************************************************
   // Checks
   // ************************************************************************

   property p_entry_lock;
      @(posedge mclk) disable iff (!nrst)
      dev_req && cmd_q == spcd_pkg::SPCD_C_LOCK_ENTRY && idx_q == 2'h2
         |-> dev_addr == `SPCD_UNLOCK1 && dev_wdata == `SPCD_D_LOCK_ENT && dev_we;
   endproperty
   a_entry_lock: assert property (p_entry_lock) else $error("lock entry code wrong"); // [R1]

   property p_entry_vol;
      @(posedge mclk) disable iff (!nrst)
      dev_req && cmd_q == spcd_pkg::SPCD_C_VOL_ENTRY && idx_q == 2'h1
         |-> dev_addr == `SPCD_UNLOCK2 && dev_wdata == `SPCD_D_55;
   endproperty
   a_entry_vol: assert property (p_entry_vol) else $error("second unlock wrong"); // [R5]

   property p_lock_clear;
      @(posedge mclk) disable iff (!nrst)
      dev_req && cmd_q == spcd_pkg::SPCD_C_LOCK_CLEAR
         |-> dev_we && dev_wdata == (idx_q == 2'h0 ? `SPCD_D_PROG : `SPCD_D_ZERO);
   endproperty
   a_lock_clear: assert property (p_lock_clear) else $error("lock clear data wrong"); // [R2]

   property p_exit_mode;
      @(posedge mclk) disable iff (!nrst)
      state_q == spcd_pkg::SPCD_DONE && cmd_q == spcd_pkg::SPCD_C_EXIT
         |=> mode_q == spcd_pkg::SPCD_MODE_ARRAY ##1 state_q == spcd_pkg::SPCD_IDLE;
   endproperty
   a_exit_mode: assert property (p_exit_mode) else $error("exit left overlay mode"); // [R3]

   property p_array_mode;
      @(posedge mclk) disable iff (!nrst)
      dev_req && cmd_q == spcd_pkg::SPCD_C_ARRAY_READ
         |-> mode_q == spcd_pkg::SPCD_MODE_ARRAY && !dev_we;
   endproperty
   a_array_mode: assert property (p_array_mode) else $error("array read in overlay"); // [R4]

   property p_read_kind;
      @(posedge mclk) disable iff (!nrst)
      dev_req && !dev_we |-> cmd_q inside {spcd_pkg::SPCD_C_LOCK_READ,
         spcd_pkg::SPCD_C_VOL_READ, spcd_pkg::SPCD_C_PROT_STAT, spcd_pkg::SPCD_C_ARRAY_READ};
   endproperty
   a_read_kind: assert property (p_read_kind) else $error("read in command cycle"); // [R11]

   property p_cmd_addr;
      @(posedge mclk) disable iff (!nrst)
      dev_req && dev_we && cmd_q != spcd_pkg::SPCD_C_VOL_WRITE
         |-> dev_addr[`SPCD_AW-1:11] == '0 && dev_wdata[15:8] == 8'h00;
   endproperty
   a_cmd_addr: assert property (p_cmd_addr) else $error("command word address too wide"); // [R12] [R13]

   property p_sector_addr;
      @(posedge mclk) disable iff (!nrst)
      dev_req && cmd_q == spcd_pkg::SPCD_C_VOL_WRITE && idx_q == 2'h1
         |-> dev_addr == sa_q && dev_we && dev_wdata == {15'h0000, wd_q[0]};
   endproperty
   a_sector_addr: assert property (p_sector_addr) else $error("sector address lost"); // [R22]

   property p_req_hold;
      @(posedge mclk) disable iff (!nrst)
      dev_req && !dev_ack |=> dev_req && $stable(dev_addr) && $stable(dev_wdata);
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("request dropped early"); // [R9]

endmodule : spcd_ctrl

/* rtl/spcd_defines.svh */
// Offsets, command codes, bus addresses and field positions of the sector protection controller
// ****************************************************************************
// Summary of operation
// [R1] Lock overlay entry: 555/AA, 2AA/55, 555/50, exactly in that order.
// [R2] In lock overlay, A0 then 0 clears lock bit; one read returns bit 0.
// [R3] Exit is 90 then 0, or single F0; both return to array reads.
// [R4] After any entry the host issues an exit before expecting array reads.
// [R5] Volatile overlay entry: 555/AA, 2AA/55, 555/E0.
// [R6] Volatile mode: A0 then sector write; data 0 sets lock, 1 clears it.
// [R7] Volatile status read: bit 0 low when protected, bits 15..1 high.
// [R8] 60 then sector read: bits 0..2 overall, volatile, persistent; upper ones.
// [R9] Only first word of a status or protection read is valid.
// [R10] All values hexadecimal; command addresses count 16-bit words.
// [R11] Command cycles are writes, except reads of data or status.
// [R12] Upper data byte is ignored in command cycles except data-bearing ones.
// [R13] Address bits above bit 10 are ignored in unlock and command cycles.
// [R14] Array data reads need no unlock or command cycles.
// [R15] Host issues reset to leave identification mode or after error flag.
// [R16] Erase suspend only during sector erase; limited operations while suspended.
// [R17] Resume commands accepted only in the matching suspend state.
// [R18] Leaving write-buffer abort needs the full reset sequence.
// [R19] One password portion per A0 program, portions in ascending order.
// [R20] Protection scheme register bits are one-time programmable; 0 is programmed.
// [R21] Programming both mode lock bits together aborts back to read mode.
// [R22] Parameter sector addresses include bits 16..11 in erase and program.
// ****************************************************************************
`ifndef SPCD_DEFINES_SVH
`define SPCD_DEFINES_SVH

// Register offsets on the software port
`define SPCD_OFS_CTRL    8'h00
`define SPCD_OFS_ADDR    8'h04
`define SPCD_OFS_WDATA   8'h08
`define SPCD_OFS_STATUS  8'h0C
`define SPCD_OFS_RDATA   8'h10

// Status field positions
`define SPCD_ST_BUSY     0
`define SPCD_ST_MODE_LO  1
`define SPCD_ST_MODE_HI  2
`define SPCD_ST_ERR      3
`define SPCD_ST_OPERR    4

// Device bus widths and command values
`define SPCD_AW          24
`define SPCD_DW          16
`define SPCD_UNLOCK1     24'h000555
`define SPCD_UNLOCK2     24'h0002AA
`define SPCD_ANY_ADDR    24'h000000
`define SPCD_D_AA        16'h00AA
`define SPCD_D_55        16'h0055
`define SPCD_D_LOCK_ENT  16'h0050
`define SPCD_D_VOL_ENT   16'h00E0
`define SPCD_D_PROG      16'h00A0
`define SPCD_D_EXIT      16'h0090
`define SPCD_D_ZERO      16'h0000
`define SPCD_D_RESET     16'h00F0
`define SPCD_D_PSTAT     16'h0060
`define SPCD_OPERR_BIT   5

`endif

/* rtl/spcd_pkg.sv */
// Types of the sector protection controller
package spcd_pkg;

   // Sequencer states, one-hot
   typedef enum logic [3:0] {
      SPCD_IDLE  = 4'h1,
      SPCD_ISSUE = 4'h2,
      SPCD_NEXT  = 4'h4,
      SPCD_DONE  = 4'h8
   } spcd_state_t;

   // Overlay mode the device is believed to be in
   typedef enum logic [1:0] {
      SPCD_MODE_ARRAY = 2'h0,
      SPCD_MODE_LOCK  = 2'h1,
      SPCD_MODE_VOL   = 2'h2
   } spcd_mode_t;

   // Commands software may order
   typedef enum logic [3:0] {
      SPCD_C_LOCK_ENTRY = 4'h0,
      SPCD_C_LOCK_CLEAR = 4'h1,
      SPCD_C_LOCK_READ  = 4'h2,
      SPCD_C_EXIT       = 4'h3,
      SPCD_C_RESET      = 4'h4,
      SPCD_C_VOL_ENTRY  = 4'h5,
      SPCD_C_VOL_WRITE  = 4'h6,
      SPCD_C_VOL_READ   = 4'h7,
      SPCD_C_PROT_STAT  = 4'h8,
      SPCD_C_ARRAY_READ = 4'h9
   } spcd_cmd_t;

endpackage : spcd_pkg

/* verification/sector_protection_command_decoder_tb.sv */
// Self-checking bench for the sector protection controller
`timescale 1ns/1ps
`include "spcd_defines.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
   $display("Error %s expected %h seen %h", n, e, g); end end

module sector_protection_command_decoder_tb;
   logic                 mclk = 1'b0;
   logic                 nrst = 1'b0;
   logic [7:0]           reg_addr = 8'h00;
   logic [31:0]          reg_wdata = 32'h0;
   logic                 reg_wr = 1'b0;
   logic                 reg_rd = 1'b0;
   logic [31:0]          reg_rdata;
   logic [31:0]          v;
   logic [3:0]           lat = 4'h0;
   logic                 dev_req, dev_we, dev_ack;
   logic [`SPCD_AW-1:0]  dev_addr;
   logic [`SPCD_DW-1:0]  dev_wdata, dev_rdata;
   int                   errors = 0;
   int                   cmp_count = 0;

   // Clock at 100 MHz
   always #5 mclk = ~mclk;

   spcd_ctrl i_dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dev_req(dev_req),
      .dev_we(dev_we), .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_ack(dev_ack),
      .dev_rdata(dev_rdata));
   spcd_flash_model i_flash (.mclk(mclk), .nrst(nrst), .lat(lat), .dev_req(dev_req),
      .dev_we(dev_we), .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_ack(dev_ack),
      .dev_rdata(dev_rdata));

   // ************************************************************
   // Register port tasks
   // ************************************************************
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr

   // Read data is looked at in the single cycle it stands
   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      reg_addr <= a; reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd

   // Order a command and wait, bounded, for busy to drop
   task automatic run(input logic [3:0] c, input logic [23:0] a, input logic [31:0] d);
      int n;
      wr(`SPCD_OFS_ADDR, {8'h00, a});
      wr(`SPCD_OFS_WDATA, d);
      wr(`SPCD_OFS_CTRL, {28'h0, c});
      for (n = 0; n < 300; n++) begin
         rd(`SPCD_OFS_STATUS);
         if (v[0] === 1'b0) break;
      end
      if (n == 300) begin errors++; $display("Error busy expected 0 seen 1"); end
   endtask : run

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset;
      rd(`SPCD_OFS_STATUS);
      `CHK("status", 32'h0, v)
      rd(8'h20);
      `CHK("unmapped", 32'h0, v)
   endtask : t_reset

   // Lock overlay: enter, read, clear, read again, two-write exit
   task automatic t_lock;
      run(4'h0, 24'h0, 32'h0);
      `CHK("mode", 2'h1, v[2:1])
      run(4'h2, 24'h0, 32'h0);
      rd(`SPCD_OFS_RDATA);
      `CHK("lock", 1'b1, v[0])
      run(4'h1, 24'h0, 32'h0);
      run(4'h2, 24'h0, 32'h0);
      rd(`SPCD_OFS_RDATA);
      `CHK("lock", 1'b0, v[0])
      run(4'h3, 24'h0, 32'h0);
      `CHK("mode", 2'h0, v[2:1])
      `CHK("operr", 1'b1, v[4])
   endtask : t_lock

   // Volatile overlay with slow device: set, status, clear, reset exit
   task automatic t_vol;
      lat <= 4'h5;
      run(4'h5, 24'h0, 32'h0);
      `CHK("mode", 2'h2, v[2:1])
      run(4'h6, 24'h0A1234, 32'h0);
      run(4'h7, 24'h0A0000, 32'h0);
      rd(`SPCD_OFS_RDATA);
      `CHK("vstat", 16'hFFFE, v[15:0])
      run(4'h7, 24'h080000, 32'h0);
      rd(`SPCD_OFS_RDATA);
      `CHK("vstat", 16'hFFFF, v[15:0])
      run(4'h8, 24'h0A0FFF, 32'h0);
      rd(`SPCD_OFS_RDATA);
      `CHK("pstat", 16'hFFFC, v[15:0])
      run(4'h6, 24'h0A5555, 32'h1);
      run(4'h7, 24'h0A0000, 32'h0);
      rd(`SPCD_OFS_RDATA);
      `CHK("vstat", 16'hFFFF, v[15:0])
      run(4'h4, 24'h0, 32'h0);
      `CHK("mode", 2'h0, v[2:1])
      `CHK("operr", 1'b0, v[4])
      lat <= 4'h0;
   endtask : t_vol

   // Refused orders and a plain array read
   task automatic t_refuse;
      run(4'h1, 24'h0, 32'h0);
      `CHK("err", 1'b1, v[3])
      wr(`SPCD_OFS_STATUS, 32'h8);
      run(4'hA, 24'h0, 32'h0);
      `CHK("err", 1'b1, v[3])
      wr(`SPCD_OFS_STATUS, 32'h8);
      rd(`SPCD_OFS_STATUS);
      `CHK("err", 1'b0, v[3])
      run(4'h9, 24'h000123, 32'h0);
      rd(`SPCD_OFS_RDATA);
      `CHK("array", 16'h5B1F, v[15:0])
   endtask : t_refuse

   task automatic summarize;
      $display("Comparisons %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : summarize

   // Main sequence after four reset cycles
   initial begin
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      t_reset();
      t_lock();
      t_vol();
      t_refuse();
      summarize();
   end

   // Watchdog well beyond the expected run length
   initial begin
      #500000;
      errors++;
      summarize();
   end
endmodule : sector_protection_command_decoder_tb

/* verification/spcd_flash_model.sv */
// Behavioural flash device answering the controller's word-cycle handshake
`timescale 1ns/1ps
`include "spcd_defines.svh"

module spcd_flash_model (
   input  wire logic                 mclk,
   input  wire logic                 nrst,
   input  wire logic [3:0]           lat,
   input  wire logic                 dev_req,
   input  wire logic                 dev_we,
   input  wire logic [`SPCD_AW-1:0]  dev_addr,
   input  wire logic [`SPCD_DW-1:0]  dev_wdata,
   output logic                      dev_ack,
   output logic      [`SPCD_DW-1:0]  dev_rdata
);
   // ************************************************************
   // Decode helpers
   // ************************************************************
   logic [3:0]  cnt_q;
   logic [1:0]  mode_q;
   logic [1:0]  unl_q;
   logic        prog_q;
   logic        exit_q;
   logic        pstat_q;
   logic        lock_q;
   logic [7:0]  prot_q;
   logic [15:0] word;
   logic [10:0] ca;
   logic [7:0]  cd;
   logic [2:0]  sec;

   assign ca  = dev_addr[10:0];   // High bits dropped in commands
   assign cd  = dev_wdata[7:0];   // Upper byte dropped
   assign sec = dev_addr[19:17];  // Word address picks sector, low bits ignored
   // Suspend, resume and scheme-register codes fall through the decode unheeded
   // Nothing here erases, programs or sets mode lock bits, so none is accepted

   // Word returned by a read in each mode
   always_comb begin
      if (mode_q == 2'h1) word = {15'h7FFF, lock_q};
      else if (mode_q == 2'h2 && pstat_q) word = {13'h1FFF, 1'b1, ~prot_q[sec], ~prot_q[sec]};
      else if (mode_q == 2'h2) word = {15'h7FFF, ~prot_q[sec]};
      else word = dev_addr[15:0] ^ 16'h5A3C; // Plain read, no unlock
   end

   // Handshake and command state; latency set by the bench
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= 4'h0; mode_q <= 2'h0; unl_q <= 2'h0; prog_q <= 1'b0;
         exit_q <= 1'b0; pstat_q <= 1'b0; lock_q <= 1'b1; prot_q <= 8'h00;
         dev_ack <= 1'b0; dev_rdata <= 16'h0000;
      end else begin
         dev_ack   <= 1'b0;
         dev_rdata <= ~dev_rdata; // Stale after first word, never held
         if (dev_req && !dev_ack) begin
            if (cnt_q != lat) cnt_q <= cnt_q + 4'h1;
            else begin
               cnt_q   <= 4'h0;
               dev_ack <= 1'b1;
               pstat_q <= 1'b0;
               if (!dev_we) dev_rdata <= word;
               else begin
                  prog_q <= 1'b0;
                  exit_q <= 1'b0;
                  if (cd == 8'hF0) begin
                     mode_q <= 2'h0;
                     unl_q  <= 2'h0;
                  end else if (exit_q && cd == 8'h00) mode_q <= 2'h0;
                  else if (prog_q && mode_q == 2'h1) begin
                     if (cd == 8'h00) lock_q <= 1'b0;
                  end else if (prog_q && mode_q == 2'h2) prot_q[sec] <= ~cd[0];
                  else if (mode_q != 2'h0) begin
                     exit_q  <= (cd == 8'h90);
                     prog_q  <= (cd == 8'hA0);
                     pstat_q <= (cd == 8'h60);
                  end else if (unl_q == 2'h0)
                     unl_q <= (ca == 11'h555 && cd == 8'hAA) ? 2'h1 : 2'h0;
                  else if (unl_q == 2'h1)
                     unl_q <= (ca == 11'h2AA && cd == 8'h55) ? 2'h2 : 2'h0;
                  else begin
                     unl_q <= 2'h0;
                     if (ca == 11'h555 && cd == 8'h50) mode_q <= 2'h1;
                     if (ca == 11'h555 && cd == 8'hE0) mode_q <= 2'h2;
                  end
               end
            end
         end
      end
   end
endmodule : spcd_flash_model
